//--- dv/acsr_checker.sv
// Concurrent checks on the pins of acsr_core.
// Assumes host pins stay put for several core clocks between changes.
`timescale 1ns/1ps
module acsr_checker
   import acsr_pkg::*;
#(
   parameter int CONV_LEN = CONV_CYCLES
)
(
   input wire logic                                 clk,
   input wire logic                                 resetn,
   input wire logic                                 sck,
   input wire logic                                 convert_start,
   input wire logic                                 serial_select_in,
   input wire logic signed [acsr_pkg::SAMPLE_W-1:0] sample_value,
   input wire logic                                 serial_result_out_o,
   input wire logic                                 serial_result_out_oe,
   input wire logic                                 power_down
);
   // ****************************************************************
   // Pin copies in the core clock domain
   // ****************************************************************
   logic [1:0]            cs_q;
   logic [1:0]            sel_q;
   logic [1:0]            sck_q;
   logic [CONV_CNT_W-1:0] low_cnt;
   wire                   s_cs  = cs_q[1];
   wire                   s_sel = sel_q[1];

   // Two-flop copies and a count of cycles spent converting
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cs_q    <= 2'b00;
         sel_q   <= 2'b00;
         sck_q   <= 2'b00;
         low_cnt <= '0;
      end
      else
      begin
         cs_q    <= {cs_q[0], convert_start};
         sel_q   <= {sel_q[0], serial_select_in};
         sck_q   <= {sck_q[0], sck};
         low_cnt <= power_down ? '0 : low_cnt + 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_both_high;
      (s_cs && s_sel)[*4];
   endsequence
   sequence s_both_low;
      (!s_cs && !s_sel && power_down)[*4];
   endsequence

   a_reset_quiet: assert property ($rose(resetn) |->
      (!serial_result_out_oe && power_down)[*2]) else $error("output active after reset");
   a_conv_length: assert property ($rose(power_down) |->
      low_cnt inside {[CONV_LEN-1:CONV_LEN+1]}) else $error("conversion length wrong");
   a_conv_no_drive: assert property (!power_down |->
      !serial_result_out_oe) else $error("output driven while converting");
   a_acq_after_end: assert property ($rose(power_down) |=>
      power_down[*3]) else $error("no acquisition after conversion");
   a_deselect_release: assert property (s_both_high |=>
      !serial_result_out_oe) else $error("output driven while deselected");
   a_both_low_drive: assert property (s_both_low |=>
      serial_result_out_oe && !serial_result_out_o) else $error("both low but not driven low");
   a_busy_low: assert property ($rose(power_down) && s_sel && !s_cs |=>
      serial_result_out_oe && !serial_result_out_o) else $error("busy edge not low");
   a_hold_on_rise: assert property ($rose(sck_q[1]) |->
      (!serial_result_out_oe || $stable(serial_result_out_o))[*3]) else $error("bit moved at rise");
endmodule : acsr_checker

bind acsr_core acsr_checker #(.CONV_LEN(CONV_LEN)) u_chk (.clk(clk), .resetn(resetn),
   .sck(sck), .convert_start(convert_start), .serial_select_in(serial_select_in),
   .sample_value(sample_value), .serial_result_out_o(serial_result_out_o),
   .serial_result_out_oe(serial_result_out_oe), .power_down(power_down));

//--- dv/acsr_host_model.sv
// Host side of the serial link: makes the shift clock and captures bits.
// Assumes a pull-up on the result line; the clock stands low between frames unless parked high for chain busy.
`timescale 1ns/1ps
module acsr_host_model
(
   output logic        sck,
   input  wire logic   sdo_o,
   input  wire logic   sdo_oe,
   output logic [16:0] word,
   output logic        word_valid
);
   wire line = sdo_oe ? sdo_o : 1'b1;   // Single converter, pull-up when released

   initial
   begin
      sck        = 1'b0;
      word       = '0;
      word_valid = 1'b0;
   end

   // One frame of n clocks, capture on the rising edge
   task read(input int n);
      word = '0;
      for (int i = 0; i < n; i++)
      begin
         #62.5 sck = 1'b1;
         word = {word[15:0], line};
         #62.5 sck = 1'b0;
      end
      #20 word_valid = 1'b1;
      #10 word_valid = 1'b0;
   endtask : read

   // Idle level of the shift clock; high at the start edge asks for chain busy
   task park(input logic lvl);
      sck <= lvl;
   endtask : park
endmodule : acsr_host_model

//--- dv/adc_conversion_serial_readout_tb.sv
// Self-checking bench of acsr_core over all chip-select and chain readouts.
// Assumes the host model on the far side and the bound checker.
`timescale 1ns/1ps
module adc_conversion_serial_readout_tb;
   import acsr_pkg::*;
   // ****************************************************************
   // Signals, clock and checking
   // ****************************************************************
   logic                       clk;
   logic                       resetn;
   logic                       sck;
   logic                       convert_start;
   logic                       serial_select_in;
   logic signed [SAMPLE_W-1:0] sample_value;
   logic                       out_o;
   logic                       out_oe;
   logic                       power_down;
   logic [16:0]                word;
   logic                       word_valid;
   logic [16:0]                exp_q[$];
   int                         fails = 0;
   int                         checked = 0;
   int                         seed_val;

   acsr_core #(.CONV_LEN(8)) u_dut (.clk(clk), .resetn(resetn), .sck(sck),
      .convert_start(convert_start), .serial_select_in(serial_select_in),
      .sample_value(sample_value), .serial_result_out_o(out_o),
      .serial_result_out_oe(out_oe), .power_down(power_down));
   acsr_host_model u_host (.sck(sck), .sdo_o(out_o), .sdo_oe(out_oe), .word(word),
      .word_valid(word_valid));

   // Clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task end_sim;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim

   task check(input logic [16:0] seen, input logic [16:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check

   // Saturated straight binary of a raw code
   function automatic logic [16:0] sat(input logic signed [SAMPLE_W-1:0] s);
      if (s < 0) return {1'b0, CODE_ZERO};
      if (s > 18'sh0_FFFF) return {1'b0, CODE_FULL};
      return {1'b0, s[15:0]};
   endfunction : sat

   task wait_pd(input logic lvl);
      int i;
      for (i = 0; i < 60 && power_down !== lvl; i++) @(negedge clk);
      if (i == 60)
      begin
         fails++;
         end_sim();
      end
   endtask : wait_pd

   // Modes: 0 3-wire, 1 3-wire busy, 2 4-wire, 3 chain, 4 chain busy, 5 4-wire busy
   task run(input int mode, input logic signed [SAMPLE_W-1:0] s);
      logic chain;
      logic busy;
      chain = (mode == 3 || mode == 4);
      busy  = (mode == 1 || mode == 4 || mode == 5);
      @(posedge clk);
      sample_value     <= s;
      serial_select_in <= !chain;
      if (mode == 4) u_host.park(1'b1);
      repeat (2) @(posedge clk);
      convert_start    <= 1'b1;
      wait_pd(1'b0);
      @(posedge clk);
      if (mode == 1) convert_start <= 1'b0;
      if (mode == 4) u_host.park(1'b0);
      if (mode == 5) serial_select_in <= 1'b0;
      wait_pd(1'b1);
      @(posedge clk);
      if (mode == 0) convert_start <= 1'b0;
      if (mode == 2) serial_select_in <= 1'b0;
      repeat (8) @(posedge clk);
      if (busy) check({15'h0, out_oe, out_o}, {15'h0, 1'b1, chain});
      exp_q.push_back(sat(s) | {busy & chain, 16'h0000});
      u_host.read(busy ? 17 : 16);
      repeat (8) @(posedge clk);
      check({16'h0, out_oe}, {16'h0, chain});
      convert_start <= 1'b0;
      repeat (8) @(posedge clk);
      check({15'h0, out_oe, out_o}, {15'h0, mode >= 2, 1'b0});
      serial_select_in <= 1'b1;
      repeat (6) @(posedge clk);
      $display("test mode %0d done", mode);
   endtask : run

   // Result watcher
   initial
   begin
      forever
      begin
         @(posedge word_valid);
         if (exp_q.size() == 0) check(17'h0_0000, 17'h1_0000);
         else check(word, exp_q.pop_front());
      end
   end

   // Main sequence
   initial
   begin
      resetn           = 1'b0;
      convert_start    = 1'b0;
      serial_select_in = 1'b1;
      sample_value     = '0;
      seed_val         = $urandom(32968);
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      repeat (8) @(posedge clk);
      for (int t = 0; t < 12; t++)
         run(t % 6, (t == 4) ? -18'sd5 : (t == 5) ? 18'sd70000 : (t == 6) ? 18'sh0_FFFF
            : $signed({2'b00, 16'($urandom)}));
      end_sim();
   end

   // Hang guard
   initial
   begin
      #500000;
      fails++;
      end_sim();
   end
endmodule : adc_conversion_serial_readout_tb

//--- rtl/acsr_core.sv
// Conversion timing, mode selection and serial result output.
// Assumes pins arrive asynchronously and the shift clock is the host's.
`timescale 1ns/1ps
module acsr_core
   import acsr_pkg::*;
#(
   parameter int CONV_LEN = CONV_CYCLES
)
(
   input  wire logic                                 clk,
   input  wire logic                                 resetn,
   input  wire logic                                 sck,
   input  wire logic                                 convert_start,
   input  wire logic                                 serial_select_in,
   input  wire logic signed [acsr_pkg::SAMPLE_W-1:0] sample_value,
   output logic                                      serial_result_out_o,
   output logic                                      serial_result_out_oe,
   output logic                                      power_down
);
   import acsr_pkg::*;

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Gray word back to binary
   function automatic logic [EDGE_W-1:0] acsr_gray2bin(input logic [EDGE_W-1:0] g);
      logic [EDGE_W-1:0] b;
      b[EDGE_W-1] = g[EDGE_W-1];
      for (int i = EDGE_W - 2; i >= 0; i--)
      begin
         b[i] = g[i] ^ b[i + 1];
      end
      return b;
   endfunction : acsr_gray2bin

   // Clamp the signed front end code into the unsigned result range
   function automatic logic [DATA_W-1:0] acsr_saturate(input logic signed [SAMPLE_W-1:0] v);
      logic [DATA_W-1:0] r;
      r = v[DATA_W-1:0];
      if (v[SAMPLE_W-1])
      begin
         r = CODE_ZERO;
      end
      else if (|v[SAMPLE_W-2:DATA_W])
      begin
         r = CODE_FULL;
      end
      return r;
   endfunction : acsr_saturate

   // Output level for a bit position; busy frames lead with a start bit
   function automatic logic acsr_bit(input logic [DATA_W-1:0] word,
                                     input logic [EDGE_W-1:0] idx,
                                     input logic              busy,
                                     input logic              chain);
      logic [EDGE_W-1:0] pos;
      logic              b;
      pos = busy ? (idx - 8'h01) : idx;
      b   = 1'b0;
      if (busy && (idx == 8'h00))
      begin
         b = chain;
      end
      else if (pos < BITS_PLAIN)
      begin
         b = word[4'(DATA_W - 1 - int'(pos))];
      end
      return b;
   endfunction : acsr_bit

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic                  rst_meta;
   logic                  rst_n;
   logic                  cnv_meta;
   logic                  cnv_s;
   logic                  cnv_d;
   logic                  sel_meta;
   logic                  sel_s;
   logic                  sel_d;
   logic                  sck_meta;
   logic                  sck_s;
   logic [EDGE_W-1:0]     gray_meta;
   logic [EDGE_W-1:0]     gray_s;
   logic [EDGE_W-1:0]     edge_bin;
   logic                  cnv_rise;
   logic                  sel_active;
   logic [EDGE_W-1:0]     idx;
   logic [EDGE_W-1:0]     limit;

   acsr_state_type        state;
   acsr_state_type        next_state;
   logic [CONV_CNT_W-1:0] conv_cnt;
   logic [CONV_CNT_W-1:0] next_conv_cnt;
   logic                  cs_mode;
   logic                  next_cs_mode;
   logic                  busy_en;
   logic                  next_busy_en;
   logic [DATA_W-1:0]     result;
   logic [DATA_W-1:0]     next_result;
   logic [SAMPLE_W-1:0]   sample_hold;
   logic [SAMPLE_W-1:0]   next_sample_hold;
   logic [EDGE_W-1:0]     snap;
   logic [EDGE_W-1:0]     next_snap;
   logic                  next_sdo;
   logic                  next_sdo_oe;
   logic                  next_power_down;

   acsr_link_if           link ();

   // ****************************************************************
   // Reset release and synchronisers
   // ****************************************************************

   // Reset asserts at once and releases through two flops
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Pin levels and the edge count pass two flops before use
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnv_meta  <= 1'b0;
         cnv_s     <= 1'b0;
         cnv_d     <= 1'b0;
         sel_meta  <= 1'b0;
         sel_s     <= 1'b0;
         sel_d     <= 1'b0;
         sck_meta  <= 1'b0;
         sck_s     <= 1'b0;
         gray_meta <= '0;
         gray_s    <= '0;
      end
      else
      begin
         cnv_meta  <= convert_start;
         cnv_s     <= cnv_meta;
         cnv_d     <= cnv_s;
         sel_meta  <= serial_select_in;
         sel_s     <= sel_meta;
         sel_d     <= sel_s;
         sck_meta  <= sck;
         sck_s     <= sck_meta;
         gray_meta <= link.edge_gray;
         gray_s    <= gray_meta;
      end
   end

   // ****************************************************************
   // Shift clock edge counter
   // ****************************************************************
   acsr_link_counter u_link (
      .sck   (sck),
      .rst_n (rst_n),
      .link  (link.link)
   );

   // ****************************************************************
   // Events and frame position
   // ****************************************************************

   // Start edge, selection and edges since the frame began
   always_comb
   begin
      edge_bin   = acsr_gray2bin(gray_s);
      cnv_rise   = cnv_s & ~cnv_d;
      sel_active = ~(cnv_s & sel_s);
      idx        = edge_bin - snap;
      limit      = busy_en ? BITS_BUSY : BITS_PLAIN;
   end

   // ****************************************************************
   // Conversion and readout control
   // ****************************************************************

   // Next state, mode, result and output
   always_comb
   begin
      next_state       = state;
      next_conv_cnt    = conv_cnt;
      next_cs_mode     = cs_mode;
      next_busy_en     = busy_en;
      next_result      = result;
      next_sample_hold = sample_hold;
      next_snap        = snap;
      next_sdo         = 1'b0;
      next_sdo_oe      = 1'b0;
      next_power_down  = 1'b1;
      case (state)
         ST_CONV:
         begin
            next_power_down = 1'b0;
            next_conv_cnt   = conv_cnt + 16'h0001;
            if (conv_cnt == CONV_CNT_W'(CONV_LEN - 1))
            begin
               next_result     = acsr_saturate(sample_hold);
               next_snap       = edge_bin;
               next_power_down = 1'b1;
               if (cs_mode)
               begin
                  next_busy_en = ~cnv_s | ~sel_s;
                  next_state   = (~cnv_s | ~sel_s) ? ST_SHIFT : ST_WAIT;
               end
               else
               begin
                  next_state = ST_SHIFT;
               end
            end
         end
         ST_WAIT:
         begin
            next_sdo_oe = ~cnv_s & ~sel_s;
            if (sel_active)
            begin
               next_snap   = edge_bin;
               next_state  = ST_SHIFT;
               next_sdo_oe = 1'b1;
               next_sdo    = result[DATA_W-1];
            end
         end
         ST_SHIFT:
         begin
            next_sdo_oe = 1'b1;
            next_sdo    = acsr_bit(result, idx, busy_en, ~cs_mode);
            if (cs_mode && (!sel_active || idx >= limit))
            begin
               next_state  = ST_DONE;
               next_sdo_oe = ~cnv_s & ~sel_s;
               next_sdo    = 1'b0;
            end
         end
         default:
         begin
            next_sdo_oe = ~cnv_s & ~sel_s;
         end
      endcase
      // A new start edge restarts unless a conversion is running
      if (cnv_rise && state != ST_CONV)
      begin
         next_state       = ST_CONV;
         next_conv_cnt    = '0;
         next_cs_mode     = sel_d;
         next_busy_en     = sel_d ? 1'b0 : sck_s;
         next_sample_hold = sample_value;
         next_sdo_oe      = 1'b0;
         next_sdo         = 1'b0;
         next_power_down  = 1'b0;
      end
   end

   // Registers of the control group
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state                <= ST_IDLE;
         conv_cnt             <= '0;
         cs_mode              <= 1'b0;
         busy_en              <= 1'b0;
         result               <= CODE_ZERO;
         sample_hold          <= '0;
         snap                 <= '0;
         serial_result_out_o  <= 1'b0;
         serial_result_out_oe <= 1'b0;
         power_down           <= 1'b1;
      end
      else
      begin
         state                <= next_state;
         conv_cnt             <= next_conv_cnt;
         cs_mode              <= next_cs_mode;
         busy_en              <= next_busy_en;
         result               <= next_result;
         sample_hold          <= next_sample_hold;
         snap                 <= next_snap;
         serial_result_out_o  <= next_sdo;
         serial_result_out_oe <= next_sdo_oe;
         power_down           <= next_power_down;
      end
   end

endmodule : acsr_core

//--- rtl/acsr_link_counter.sv
// Shift clock domain: counts falling edges of the host shift clock.
// Assumes the count leaves the domain only as a gray word.
`timescale 1ns/1ps
module acsr_link_counter
   import acsr_pkg::*;
(
   input  wire logic    sck,
   input  wire logic    rst_n,
   acsr_link_if.link    link
);
   import acsr_pkg::*;

   logic [EDGE_W-1:0] count;
   logic [EDGE_W-1:0] next_count;
   logic [EDGE_W-1:0] next_gray;

   // ****************************************************************
   // Edge counter
   // ****************************************************************

   // Binary advance and gray encode
   always_comb
   begin
      next_count = count + 8'h01;
      next_gray  = next_count ^ (next_count >> 1);
   end

   // Only the falling edge moves the output, so bits hold over the rising edge
   always_ff @(negedge sck or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count          <= '0;
         link.edge_gray <= '0;
      end
      else
      begin
         count          <= next_count;
         link.edge_gray <= next_gray;
      end
   end

endmodule : acsr_link_counter

//--- rtl/acsr_link_if.sv
// Carrier between the shift clock edge counter and the core logic.
// Assumes the core synchronises the gray word before reading it.
`timescale 1ns/1ps
interface acsr_link_if;
   import acsr_pkg::*;

   logic [EDGE_W-1:0] edge_gray;   // Gray count of shift clock falling edges

   modport link (output edge_gray);
   modport core (input  edge_gray);

endinterface : acsr_link_if

//--- rtl/acsr_pkg.sv
// Shared constants and types of the conversion and serial readout block.
// Assumes a 100 MHz core clock and a free-standing shift clock from the host.
package acsr_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int DATA_W     = 16;   // Result word width
   localparam int SAMPLE_W   = 18;   // Signed raw code from the front end
   localparam int EDGE_W     = 8;    // Shift clock edge counter width
   localparam int CONV_CNT_W = 16;   // Conversion timer width

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS    = 10;
   localparam int CONV_TIME_MIN_NS = 500;  // Plain default, host side only
   localparam int CONV_TIME_MAX_NS = 800;  // Plain default
   // Longest time rounds down, never under one cycle
   localparam int CONV_CYCLES_CALC = CONV_TIME_MAX_NS / CLK_PERIOD_NS;
   localparam int CONV_CYCLES      = (CONV_CYCLES_CALC < 1) ? 1 : CONV_CYCLES_CALC;

   // ****************************************************************
   // Frame lengths in shift clock falling edges
   // ****************************************************************
   localparam logic [EDGE_W-1:0] BITS_PLAIN = 8'h10;  // Result bits only
   localparam logic [EDGE_W-1:0] BITS_BUSY  = 8'h11;  // Start bit and result

   // ****************************************************************
   // Saturation limits
   // ****************************************************************
   localparam logic [DATA_W-1:0] CODE_FULL = 16'hFFFF;
   localparam logic [DATA_W-1:0] CODE_ZERO = 16'h0000;

   // ****************************************************************
   // Control state
   // ****************************************************************
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,   // No result yet, acquiring
      ST_CONV  = 5'b00010,   // Conversion running
      ST_WAIT  = 5'b00100,   // Result held, waiting for selection
      ST_SHIFT = 5'b01000,   // Frame on the serial output
      ST_DONE  = 5'b10000    // Frame ended, output driven low while both pins are low, else released
   } acsr_state_type;

endpackage : acsr_pkg

//--- rtl/acsr_top_note.sv
// Holds no logic: the top module of the block is acsr_core.
// Assumes nothing of its surroundings; the block's logic lives in the other rtl files.
